//--- asop_top.sv
// Top: digital side of a sampling converter output port with AXI4-Lite control
// Assumes: encode clock and analog code arrive asynchronously; capture logic outside
module asop_top #(
    parameter int unsigned LATENCY = asop_pkg::ASOP_LATENCY
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Encode clock pair and analog code
    input wire logic encode_clk_pos,
    input wire logic encode_clk_neg,
    input wire logic [asop_pkg::ASOP_DATA_W-1:0] analog_code,
    input wire logic analog_over,
    input wire logic analog_under,
    // Parallel output port (oe low = driving)
    output logic [asop_pkg::ASOP_DATA_W-1:0] sample_word_out,
    output logic [asop_pkg::ASOP_DATA_W-1:0] sample_word_oe_n,
    output logic range_overflow_flag,
    output logic range_overflow_oe_n,
    output logic data_valid_strobe_n,
    output logic data_valid_strobe_p,
    output logic strobe_oe_n,
    // Analog controls
    output logic analog_power_down,
    output logic dither_on,
    output logic front_gain_sel,
    output logic duty_stab_on,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);
    import asop_pkg::*;

    localparam int unsigned DW = ASOP_DATA_W;

    typedef struct packed {
        logic [31:0] ctrl_r;
        logic [ASOP_IRQ_W-1:0] irq_stat_r;
        logic [ASOP_IRQ_W-1:0] irq_mask_r;
        logic enc_prev_r;
        logic [DW:0] held_r;
        logic [31:0] count_r;
        logic [DW-1:0] word_r;
        logic [DW-1:0] word_oe_n_r;
        logic of_r;
        logic of_oe_n_r;
        logic strb_n_r;
        logic strb_p_r;
        logic strb_oe_n_r;
        logic pwdn_r;
        logic dither_on_r;
        logic gain_r;
        logic stab_r;
        logic aw_full_r;
        logic [7:0] aw_addr_r;
        logic w_full_r;
        logic [31:0] w_data_r;
        logic [3:0] w_strb_r;
        logic bvalid_r;
        logic [1:0] bresp_r;
        logic rvalid_r;
        logic [31:0] rdata_r;
        logic [1:0] rresp_r;
        logic irq_r;
    } asop_top_type;

    asop_top_type q_r, q_nxt;
    logic enc_pos_s, enc_neg_s, over_s, under_s;
    logic [DW-1:0] code_s;
    logic [DW:0] pipe_out;
    logic enc_rise;

    // Encode pair and analog code enter through two flops
    asop_sync u_sync_pos (.clk(clk), .sys_rst(sys_rst), .din(encode_clk_pos), .dout(enc_pos_s));
    asop_sync u_sync_neg (.clk(clk), .sys_rst(sys_rst), .din(encode_clk_neg), .dout(enc_neg_s));
    asop_sync u_sync_ov (.clk(clk), .sys_rst(sys_rst), .din(analog_over), .dout(over_s));
    asop_sync u_sync_un (.clk(clk), .sys_rst(sys_rst), .din(analog_under), .dout(under_s));
    for (genvar g = 0; g < DW; g++) begin : g_code
        asop_sync u_sync_code (.clk(clk), .sys_rst(sys_rst), .din(analog_code[g]), .dout(code_s[g]));
    end

    // Positive above negative marks encode high; rising is the hold instant
    assign enc_rise = (enc_pos_s & ~enc_neg_s) & ~q_r.enc_prev_r;

    // Word and flag travel together through the latency pipeline
    asop_pipe #(.DEPTH(LATENCY), .W(DW + 1)) u_pipe (
        .clk(clk),
        .sys_rst(sys_rst),
        .adv(enc_rise),
        .din(q_nxt.held_r),
        .dout(pipe_out)
    );

    always_comb begin
        logic [DW-1:0] fmt;
        logic [1:0] mode;
        logic [ASOP_IRQ_W-1:0] ev;
        logic [31:0] wmask;
        logic [31:0] rd;
        logic ok;
        fmt = '0;
        mode = '0;
        ev = '0;
        wmask = '0;
        rd = '0;
        ok = 1'b0;
        q_nxt = q_r;
        q_nxt.enc_prev_r = enc_pos_s & ~enc_neg_s;
        mode = q_r.ctrl_r[ASOP_CTRL_MODE_LSB +: 2];

        // Hold sample with its range flag at the encode edge
        if (enc_rise) begin
            q_nxt.held_r = {over_s | under_s, code_s};
            q_nxt.count_r = q_r.count_r + 32'h1;
        end

        // Static selections applied to every emerging word
        fmt = pipe_out[DW-1:0];
        if (mode == ASOP_MODE_TC_STAB || mode == ASOP_MODE_TC_NOSTAB) begin
            fmt[DW-1] = ~fmt[DW-1];
        end
        if (q_r.ctrl_r[ASOP_CTRL_SCRM_BIT]) begin
            fmt[DW-1:1] = fmt[DW-1:1] ^ {(DW - 1){fmt[0]}};
        end
        if (enc_rise) begin
            q_nxt.word_r = fmt;
            q_nxt.of_r = pipe_out[DW];
            q_nxt.strb_n_r = ~q_r.strb_n_r;
            q_nxt.strb_p_r = q_r.strb_n_r;
        end
        q_nxt.stab_r = (mode == ASOP_MODE_OB_STAB) || (mode == ASOP_MODE_TC_STAB);
        q_nxt.pwdn_r = q_r.ctrl_r[ASOP_CTRL_PWDN_BIT];
        q_nxt.dither_on_r = q_r.ctrl_r[ASOP_CTRL_DITHER_ON_BIT];
        q_nxt.gain_r = q_r.ctrl_r[ASOP_CTRL_GAIN_BIT];

        // Outputs float on power-down or output enable high
        q_nxt.word_oe_n_r = {DW{q_r.ctrl_r[ASOP_CTRL_PWDN_BIT] | q_r.ctrl_r[ASOP_CTRL_OEN_BIT]}};
        q_nxt.of_oe_n_r = q_r.ctrl_r[ASOP_CTRL_PWDN_BIT] | q_r.ctrl_r[ASOP_CTRL_OEN_BIT];
        q_nxt.strb_oe_n_r = q_r.ctrl_r[ASOP_CTRL_PWDN_BIT] | q_r.ctrl_r[ASOP_CTRL_OEN_BIT];

        // AXI write channels, taken in either order
        if (s_axi_awvalid && !q_r.aw_full_r) begin
            q_nxt.aw_full_r = 1'b1;
            q_nxt.aw_addr_r = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q_r.w_full_r) begin
            q_nxt.w_full_r = 1'b1;
            q_nxt.w_data_r = s_axi_wdata;
            q_nxt.w_strb_r = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            q_nxt.bvalid_r = 1'b0;
            q_nxt.aw_full_r = 1'b0;
            q_nxt.w_full_r = 1'b0;
        end

        // Interrupt events: set wins over clear
        ev[ASOP_IRQ_SAMPLE_BIT] = enc_rise;
        ev[ASOP_IRQ_RANGE_BIT] = enc_rise & pipe_out[DW];
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{q_r.w_strb_r[b]}};
        end
        if (q_r.aw_full_r && q_r.w_full_r && !q_r.bvalid_r) begin
            q_nxt.bvalid_r = 1'b1;
            q_nxt.bresp_r = ASOP_RESP_OKAY;
            case (q_r.aw_addr_r & 8'hfc)
                ASOP_CTRL_OFF: q_nxt.ctrl_r = (q_r.ctrl_r & ~wmask) | (q_r.w_data_r & wmask);
                ASOP_IRQ_STAT_OFF: q_nxt.irq_stat_r = q_r.irq_stat_r & ~(q_r.w_data_r[ASOP_IRQ_W-1:0]
                    & wmask[ASOP_IRQ_W-1:0]);
                ASOP_IRQ_MASK_OFF: q_nxt.irq_mask_r = (q_r.irq_mask_r & ~wmask[ASOP_IRQ_W-1:0])
                    | (q_r.w_data_r[ASOP_IRQ_W-1:0] & wmask[ASOP_IRQ_W-1:0]);
                ASOP_STATUS_OFF, ASOP_SAMPLE_OFF, ASOP_COUNT_OFF: q_nxt.bresp_r = ASOP_RESP_OKAY;
                default: q_nxt.bresp_r = ASOP_RESP_SLVERR;
            endcase
        end
        q_nxt.irq_stat_r = q_nxt.irq_stat_r | ev;
        q_nxt.irq_r = |(q_nxt.irq_stat_r & q_r.irq_mask_r);

        // AXI read channel
        if (s_axi_rvalid && s_axi_rready) begin
            q_nxt.rvalid_r = 1'b0;
        end
        if (s_axi_arvalid && !q_r.rvalid_r) begin
            ok = 1'b1;
            case (s_axi_araddr & 8'hfc)
                ASOP_CTRL_OFF: rd = q_r.ctrl_r & 32'h0000_007f;
                ASOP_STATUS_OFF: rd = {26'h0, q_r.stab_r, q_r.of_r, q_r.strb_n_r, q_r.gain_r,
                    q_r.dither_on_r, q_r.pwdn_r};
                ASOP_IRQ_STAT_OFF: rd = {30'h0, q_r.irq_stat_r};
                ASOP_IRQ_MASK_OFF: rd = {30'h0, q_r.irq_mask_r};
                ASOP_SAMPLE_OFF: rd = {15'h0, q_r.of_r, q_r.word_r};
                ASOP_COUNT_OFF: rd = q_r.count_r;
                default: ok = 1'b0;
            endcase
            q_nxt.rvalid_r = 1'b1;
            q_nxt.rdata_r = rd;
            q_nxt.rresp_r = ok ? ASOP_RESP_OKAY : ASOP_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q_r <= '0;
            q_r.ctrl_r <= ASOP_CTRL_RST;
            q_r.word_oe_n_r <= '1;
            q_r.of_oe_n_r <= 1'b1;
            q_r.strb_oe_n_r <= 1'b1;
            q_r.strb_n_r <= 1'b1;
            q_r.pwdn_r <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sample_word_out = q_r.word_r;
    assign sample_word_oe_n = q_r.word_oe_n_r;
    assign range_overflow_flag = q_r.of_r;
    assign range_overflow_oe_n = q_r.of_oe_n_r;
    assign data_valid_strobe_n = q_r.strb_n_r;
    assign data_valid_strobe_p = q_r.strb_p_r;
    assign strobe_oe_n = q_r.strb_oe_n_r;
    assign analog_power_down = q_r.pwdn_r;
    assign dither_on = q_r.dither_on_r;
    assign front_gain_sel = q_r.gain_r;
    assign duty_stab_on = q_r.stab_r;
    assign s_axi_awready = ~q_r.aw_full_r;
    assign s_axi_wready = ~q_r.w_full_r;
    assign s_axi_bresp = q_r.bresp_r;
    assign s_axi_bvalid = q_r.bvalid_r;
    assign s_axi_arready = ~q_r.rvalid_r;
    assign s_axi_rdata = q_r.rdata_r;
    assign s_axi_rresp = q_r.rresp_r;
    assign s_axi_rvalid = q_r.rvalid_r;
    assign irq = q_r.irq_r;
endmodule // asop_top

//--- asop_pkg.sv
// Package: constants and types for the sample output port
// Assumes: shared by the top module and its two leaf modules
package asop_pkg;
    localparam int unsigned ASOP_DATA_W = 16;
    localparam int unsigned ASOP_LATENCY = 7;
    localparam int unsigned ASOP_CLK_PERIOD_NS = 10;
    // Register byte offsets
    localparam logic [7:0] ASOP_CTRL_OFF = 8'h00;
    localparam logic [7:0] ASOP_STATUS_OFF = 8'h04;
    localparam logic [7:0] ASOP_IRQ_STAT_OFF = 8'h08;
    localparam logic [7:0] ASOP_IRQ_MASK_OFF = 8'h0c;
    localparam logic [7:0] ASOP_SAMPLE_OFF = 8'h10;
    localparam logic [7:0] ASOP_COUNT_OFF = 8'h14;
    // Control fields
    localparam int unsigned ASOP_CTRL_PWDN_BIT = 0;
    localparam int unsigned ASOP_CTRL_DITHER_ON_BIT = 1;
    localparam int unsigned ASOP_CTRL_SCRM_BIT = 2;
    localparam int unsigned ASOP_CTRL_GAIN_BIT = 3;
    localparam int unsigned ASOP_CTRL_OEN_BIT = 4;
    localparam int unsigned ASOP_CTRL_MODE_LSB = 5;
    localparam logic [31:0] ASOP_CTRL_RST = 32'h0000_0011;
    // Interrupt fields
    localparam int unsigned ASOP_IRQ_SAMPLE_BIT = 0;
    localparam int unsigned ASOP_IRQ_RANGE_BIT = 1;
    localparam int unsigned ASOP_IRQ_W = 2;
    // AXI responses
    localparam logic [1:0] ASOP_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASOP_RESP_SLVERR = 2'h2;
    // Format select levels
    typedef enum logic [1:0] {
        ASOP_MODE_OB_NOSTAB = 2'h0,
        ASOP_MODE_OB_STAB = 2'h1,
        ASOP_MODE_TC_STAB = 2'h2,
        ASOP_MODE_TC_NOSTAB = 2'h3
    } asop_mode_type;
endpackage

//--- asop_sync.sv
// Two-flop synchroniser for one level
// Assumes: input comes from outside the clk domain
module asop_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Level
    input wire logic din,
    output logic dout
);
    import asop_pkg::*;
    typedef struct packed {
        logic s1_r;
        logic s2_r;
    } asop_sync_type;
    asop_sync_type q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        q_nxt.s1_r = din;
        q_nxt.s2_r = q_r.s1_r;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
    assign dout = q_r.s2_r;
endmodule // asop_sync

//--- asop_pipe.sv
// Result pipeline: word and range flag delayed together
// Assumes: advanced once per encode edge
module asop_pipe #(
    parameter int unsigned DEPTH = 7,
    parameter int unsigned W = 17
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Stream
    input wire logic adv,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    import asop_pkg::*;
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] stage_r;
    } asop_pipe_type;
    asop_pipe_type q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        if (adv) begin
            q_nxt.stage_r[0] = din;
            for (int i = 1; i < DEPTH; i++) begin
                q_nxt.stage_r[i] = q_r.stage_r[i-1];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
    assign dout = q_r.stage_r[DEPTH-1];
endmodule // asop_pipe

//--- asop_top_asserts.sv
// Checker: port-level properties of the sample output port
// Assumes: bound to asop_top, clk domain only
module asop_top_asserts (
    input logic clk,
    input logic sys_rst,
    input logic [15:0] sample_word_out,
    input logic [15:0] sample_word_oe_n,
    input logic range_overflow_flag,
    input logic range_overflow_oe_n,
    input logic data_valid_strobe_n,
    input logic data_valid_strobe_p,
    input logic strobe_oe_n,
    input logic analog_power_down,
    input logic s_axi_awready,
    input logic s_axi_bvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    strobe_pair_a: assert property (data_valid_strobe_p == !data_valid_strobe_n)
        else $error("strobe pair not inverse");
    strobe_gap_a: assert property ($changed(data_valid_strobe_n) |=> $stable(data_valid_strobe_n) [*3])
        else $error("strobe toggled twice in one sample");
    word_hold_a: assert property ($stable(data_valid_strobe_n) |->
        $stable(sample_word_out) && $stable(range_overflow_flag)) else $error("word moved without strobe");
    oe_group_a: assert property (sample_word_oe_n == {16{range_overflow_oe_n}}
        && strobe_oe_n == range_overflow_oe_n) else $error("output enables disagree");
    pwdn_float_a: assert property (analog_power_down && $past(analog_power_down) |-> range_overflow_oe_n)
        else $error("outputs driven in power down");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken during response");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during response");
endmodule // asop_top_asserts

bind asop_top asop_top_asserts u_chk (.clk, .sys_rst, .sample_word_out, .sample_word_oe_n, .range_overflow_flag,
    .range_overflow_oe_n, .data_valid_strobe_n, .data_valid_strobe_p, .strobe_oe_n, .analog_power_down,
    .s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- asop_capture_model.sv
// Capture model: latches each word at a data-valid strobe edge
// Assumes: strobes and word come from the port, sampled by clk
module asop_capture_model (
    input logic clk,
    input logic strobe_n,
    input logic strobe_p,
    input logic [15:0] word,
    input logic flag,
    input logic unscramble,
    output logic [15:0] cap_word,
    output logic cap_flag,
    output int cap_cnt
);
    logic prev_n = 1'b1;
    initial begin
        cap_cnt = 0;
        cap_word = 16'h0000;
        cap_flag = 1'b0;
    end
    always @(posedge clk) begin
        prev_n <= strobe_n;
        if (strobe_n != prev_n && strobe_p == !strobe_n) begin
            cap_word <= unscramble ? word ^ {{15{word[0]}}, 1'b0} : word;
            cap_flag <= flag;
            cap_cnt <= cap_cnt + 1;
        end
    end
endmodule // asop_capture_model

//--- asop_top_tb.sv
// Testbench: sample words, formats, floats, interrupt and control bus
// Assumes: asop_pkg, asop_top and the capture model compiled first
module asop_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import asop_pkg::*;
    logic clk = 0, sys_rst = 1, encode_clk_pos = 0, encode_clk_neg, cf, unscr = 0;
    logic [15:0] analog_code = 0, sample_word_out, sample_word_oe_n, cw;
    logic analog_over = 0, analog_under = 0, range_overflow_flag, range_overflow_oe_n;
    logic data_valid_strobe_n, data_valid_strobe_p, strobe_oe_n, analog_power_down;
    logic dither_on, front_gain_sel, duty_stab_on, irq;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int error_cnt = 0, checks_done = 0, cc;
    always #5 clk = ~clk;
    always #62.5 encode_clk_pos = ~encode_clk_pos;
    assign encode_clk_neg = ~encode_clk_pos;
    asop_top uut (.clk, .sys_rst, .encode_clk_pos, .encode_clk_neg, .analog_code, .analog_over, .analog_under,
        .sample_word_out, .sample_word_oe_n, .range_overflow_flag, .range_overflow_oe_n, .data_valid_strobe_n,
        .data_valid_strobe_p, .strobe_oe_n, .analog_power_down, .dither_on, .front_gain_sel, .duty_stab_on,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    asop_capture_model cap (.clk, .strobe_n(data_valid_strobe_n), .strobe_p(data_valid_strobe_p),
        .word(sample_word_out), .flag(range_overflow_flag), .unscramble(unscr), .cap_word(cw), .cap_flag(cf),
        .cap_cnt(cc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        logic aw = 1, w = 1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while ((aw || w || !s_axi_bvalid) && n < 200) begin
            @(posedge clk);
            n++;
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 0;
            end
        end
        r = s_axi_bresp;
        s_axi_bready <= 0;
        if (n >= 200) error_cnt++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        logic ar = 1;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        while ((ar || !s_axi_rready || !s_axi_rvalid) && n < 200) begin
            @(posedge clk);
            n++;
            if (!ar) s_axi_rready <= 1;
            if (ar && s_axi_arready) begin
                ar = 0;
                s_axi_arvalid <= 0;
            end
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        if (n >= 200) error_cnt++;
    endtask
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rd(ASOP_CTRL_OFF, d, r);
        chk(d, ASOP_CTRL_RST);
        chk({analog_power_down, sample_word_oe_n, strobe_oe_n}, 18'h3ffff);
        wr(ASOP_CTRL_OFF, 32'h10, r);
        chk(r, ASOP_RESP_OKAY);
        rd(ASOP_STATUS_OFF, d, r);
        chk({analog_power_down, sample_word_oe_n}, 17'h0ffff);
    endtask
    task automatic run_case(input logic [7:0] c, input logic [15:0] b, input logic ov, input logic un);
        logic [1:0] r;
        logic [15:0] e;
        logic [15:0] w;
        int c0;
        wr(ASOP_CTRL_OFF, {24'h0, c}, r);
        unscr <= c[2];
        @(negedge encode_clk_pos);
        @(posedge clk);
        analog_code <= ~b;
        analog_over <= 0;
        analog_under <= 0;
        repeat (2) @(negedge encode_clk_pos);
        @(posedge clk);
        analog_code <= b;
        analog_over <= ov;
        analog_under <= un;
        @(posedge encode_clk_pos);
        c0 = cc;
        e = c[6] ? b ^ 16'h8000 : b;
        for (int i = 0; i < 2000 && cc < c0 + 7; i++) @(posedge clk);
        chk({cf, cw}, {1'b0, ~e});
        for (int i = 0; i < 2000 && cc < c0 + 8; i++) @(posedge clk);
        chk({cf, cw}, {ov | un, e});
        chk({dither_on, front_gain_sel, duty_stab_on, sample_word_oe_n}, {c[1], c[3], c[6] ^ c[5], 16'h0});
        w = c[2] ? e ^ {{15{e[0]}}, 1'b0} : e;
        @(posedge encode_clk_pos);
        chk({range_overflow_flag, sample_word_out}, {ov | un, w});
    endtask
    task automatic t_irq;
        logic [31:0] d;
        logic [1:0] r;
        wr(ASOP_IRQ_MASK_OFF, 32'h0, r);
        rd(ASOP_IRQ_STAT_OFF, d, r);
        chk({d[1], irq}, 2'h2);
        wr(ASOP_IRQ_MASK_OFF, 32'h2, r);
        rd(ASOP_CTRL_OFF, d, r);
        chk(irq, 1);
        wr(ASOP_IRQ_STAT_OFF, 32'h2, r);
        rd(ASOP_CTRL_OFF, d, r);
        chk(irq, 0);
        rd(8'h40, d, r);
        chk(r, ASOP_RESP_SLVERR);
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 0;
        t_reset;
        run_case(8'h00, 16'h1234, 0, 0);
        run_case(8'h20, 16'h8001, 1, 0);
        run_case(8'h42, 16'h00ff, 0, 1);
        run_case(8'h6c, 16'h7ffe, 0, 0);
        run_case(8'h0e, 16'hfffe, 0, 0);
        t_irq;
        stop_test;
    end
    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
endmodule // asop_top_tb
